// file: core/hsfd_pkg.sv
// Operation
// RULE_01 - store error during configuration read: fault, then permanent store-fault latch.
// RULE_02 - transistor checks run after configuration read and before every retry; the code skips them when surge, high and low input faults restart via standby.
// RULE_03 - damaged-transistor faults pass through fault state straight to latch-off.
// RULE_04 - drain-source short: current over limit, gate low, weak pull-down active.
// RULE_05 - short current limit is selected by the current-sense range.
// RULE_06 - each damaged-transistor fault has matching enable, mask and status bits.
// RULE_07 - in transistor check, gate high with current over limit is gate-drain short.
// RULE_08 - gate not below 1 V within 10 ms of pull-down is gate-drain short.
// RULE_09 - gate rising again with current over limit after slow drop is gate-drain short.
// RULE_10 - watchdog expiry without power good and gate low gives gate-source short.
// RULE_11 - watchdog timer times the gate-source check even with watchdog fault off.
// RULE_12 - software keeps gate-source short disabled whenever boost mode is used.
// RULE_13 - low input threshold is digital in digital mode, comparator otherwise.
// RULE_14 - low input persisting through its timer faults and slowly pulls the gate.
// RULE_15 - low input hysteresis 2 to 13 V gates the exit from idle-wait.
// RULE_16 - low input detection arms only after threshold crossing and enable deglitch.
// RULE_17 - high input persisting through its timer faults and slowly pulls the gate.
// RULE_18 - after high input fault, restart below limit minus 0x60 or comparator.
// RULE_19 - surge above limit through its timer faults with fast or two-step pull-down.
// RULE_20 - after surge fault, restart once input is below surge limit minus 5 V.
// RULE_21 - output low through its timer faults, slow pull-down, retry after cool-down.
// RULE_22 - output low latches off; software sets its threshold below the input one.
// RULE_23 - status bits and fault output stay set until clear, enable restart, power cycle.
package hsfd_pkg;
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned CNT_W        = 24;
  localparam int unsigned GD_WIN_MS    = 10;
  localparam int unsigned GD_WIN_CYC_D = GD_WIN_MS * CLK_MHZ * 1000;
  localparam int unsigned DG_TIME_US   = 1;
  localparam int unsigned DG_CYC_D     = DG_TIME_US * CLK_MHZ;
  localparam int unsigned WD_TIME_MS   = 1;
  localparam int unsigned WD_CYC_D     = WD_TIME_MS * CLK_MHZ * 1000;
  localparam int unsigned COOL_TIME_MS = 1;
  localparam int unsigned COOL_CYC_D   = COOL_TIME_MS * CLK_MHZ * 1000;
  localparam int unsigned CHK_TIME_US  = 1;
  localparam int unsigned CHK_CYC_D    = CHK_TIME_US * CLK_MHZ;
  localparam int unsigned ENDG_TIME_US = 1;
  localparam int unsigned ENDG_CYC_D   = ENDG_TIME_US * CLK_MHZ;

  // byte offsets of the register words
  localparam logic [5:0] OFS_ENABLE    = 6'h00;
  localparam logic [5:0] OFS_MASK      = 6'h04;
  localparam logic [5:0] OFS_STATUS    = 6'h08;
  localparam logic [5:0] OFS_CONFIG    = 6'h0C;
  localparam logic [5:0] OFS_LOW_IN    = 6'h10;
  localparam logic [5:0] OFS_HIGH_IN   = 6'h14;
  localparam logic [5:0] OFS_SURGE     = 6'h18;
  localparam logic [5:0] OFS_LOW_OUT   = 6'h1C;
  localparam logic [5:0] OFS_STATE     = 6'h20;

  // fault bit positions, shared by enable, mask and status
  localparam int unsigned NFLT            = 8;
  localparam int unsigned FB_DRAIN_SOURCE = 0;
  localparam int unsigned FB_GATE_DRAIN   = 1;
  localparam int unsigned FB_GATE_SOURCE  = 2;
  localparam int unsigned FB_LOW_IN       = 3;
  localparam int unsigned FB_HIGH_IN      = 4;
  localparam int unsigned FB_SURGE        = 5;
  localparam int unsigned FB_LOW_OUT      = 6;
  localparam int unsigned FB_STORE        = 7;

  // config word fields
  localparam int unsigned CF_DIGITAL   = 0;
  localparam int unsigned CF_CS_LSB    = 1;
  localparam int unsigned CF_VT_LSB    = 3;
  localparam int unsigned CF_HYST_LSB  = 5;
  localparam int unsigned CF_OUV_RETRY = 9;

  localparam logic [7:0]  RST_ENABLE   = 8'h7F;
  localparam logic [7:0]  RST_MASK     = 8'h00;
  localparam logic [9:0]  RST_CONFIG   = 10'h001;
  localparam logic [11:0] RST_LOW_IN   = 12'h000;
  localparam logic [11:0] RST_HIGH_IN  = 12'hFFF;
  localparam logic [11:0] RST_SURGE    = 12'hFFF;
  localparam logic [11:0] RST_LOW_OUT  = 12'h000;

  // voltage codes: high input hysteresis, surge 5 V on 88 V range, low hyst
  localparam logic [12:0] HIGH_HYST    = 13'h0060;
  localparam logic [12:0] SURGE_HYST   = 13'h00E9;
  localparam logic [12:0] LOW_HYST_BASE = 13'h005D;
  localparam logic [12:0] LOW_HYST_STEP = 13'h0022;

  // short limits in mA for 12.5, 25, 50, 100 mV ranges at 1 milliohm
  localparam logic [15:0] SHORT_LIM_0  = 16'h00F0;
  localparam logic [15:0] SHORT_LIM_1  = 16'h0208;
  localparam logic [15:0] SHORT_LIM_2  = 16'h044C;
  localparam logic [15:0] SHORT_LIM_3  = 16'h0898;

  typedef enum logic [3:0] {
    ST_POR   = 4'b0000,
    ST_READ  = 4'b0001,
    ST_CHK   = 4'b0010,
    ST_STBY  = 4'b0011,
    ST_PWRUP = 4'b0100,
    ST_ON    = 4'b0101,
    ST_FAULT = 4'b0110,
    ST_LATCH = 4'b0111,
    ST_MEM   = 4'b1000,
    ST_COOL  = 4'b1001
  } hsfd_state_t;

  // lower code is higher priority
  typedef enum logic [2:0] {
    CS_MEM     = 3'b000,
    CS_DAMAGED = 3'b001,
    CS_SURGE   = 3'b010,
    CS_HIGH    = 3'b011,
    CS_LOW     = 3'b100,
    CS_OUT     = 3'b101,
    CS_WD      = 3'b110,
    CS_NONE    = 3'b111
  } hsfd_cause_t;

  typedef struct packed {
    logic [11:0] vin;
    logic [11:0] vout;
    logic [15:0] isense_ma;
    logic        vgs_above_1v;
    logic        fully_enhanced;
    logic        ana_low_in;
    logic        ana_high_in;
    logic        ana_low_out;
  } hsfd_sense_t;

  typedef struct packed {
    logic on;
    logic slow_pd;
    logic fast_pd;
  } hsfd_gate_t;
endpackage

// file: core/hsfd_core.sv
`timescale 1ns/1ps
module hsfd_core
  import hsfd_pkg::*;
#(
  parameter int unsigned DG_CYC     = DG_CYC_D,
  parameter int unsigned WD_CYC     = WD_CYC_D,
  parameter int unsigned GD_WIN_CYC = GD_WIN_CYC_D,
  parameter int unsigned COOL_CYC   = COOL_CYC_D,
  parameter int unsigned CHK_CYC    = CHK_CYC_D,
  parameter int unsigned ENDG_CYC   = ENDG_CYC_D
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire hsfd_sense_t sense,
  input  wire logic        cfg_read_done,
  input  wire logic        cfg_mem_err,
  input  wire logic        enable_pin,
  output hsfd_gate_t       gate_ctl,
  output logic             power_good_output,
  output logic             fault_output
);
  localparam int unsigned CMAX = (1 << CNT_W) - 1;

  initial begin
    if (DG_CYC < 1 || WD_CYC < 1 || GD_WIN_CYC < 1 || COOL_CYC < 1 ||
        CHK_CYC < 1 || ENDG_CYC < 1 || DG_CYC > CMAX || WD_CYC > CMAX ||
        GD_WIN_CYC > CMAX || COOL_CYC > CMAX || CHK_CYC > CMAX ||
        ENDG_CYC > CMAX)
      $error("hsfd_core: timer count out of range");
  end

  hsfd_state_t        state_r, state_nxt;
  hsfd_cause_t        cause_r, cause_nxt, new_cause;
  hsfd_gate_t         gate_r;
  logic [CNT_W-1:0]   st_cnt_r;
  logic [NFLT-1:0]    enable_r, mask_r, status_r, set_vec;
  logic [9:0]         config_r;
  logic [11:0]        low_in_r, high_in_r, surge_r, low_out_r;
  logic               wait_r, pg_r, fpin_r, uv_armed_r, gd_dropped_r;
  logic               en_q_r, en_low_seen_r;
  logic [31:0]        rdata_r, rd_mux;
  logic               wr_take, clr_req;
  logic               digital, over_short, vgs_hi;
  logic [15:0]        short_lim;
  logic [12:0]        vin13, low_hyst, surge_hyst;
  logic               uv_low, uv_ok, ov_high, ov_clear;
  logic               surge_high, surge_clear, ouv_low;
  logic               pd_state, wd_hit, gd_win_hit;
  logic               f_ds, f_gd, f_gs;
  logic [3:0]         dg_cond, dg_act, dg_hit;
  logic [CNT_W-1:0]   dg_cnt [4];

  // ---------------- sense decoding ----------------
  assign digital = config_r[CF_DIGITAL];
  assign vgs_hi  = sense.vgs_above_1v;
  assign vin13   = {1'b0, sense.vin};

  always_comb begin
    case (config_r[CF_CS_LSB +: 2]) // RULE_05
      2'd0:    short_lim = SHORT_LIM_0;
      2'd1:    short_lim = SHORT_LIM_1;
      2'd2:    short_lim = SHORT_LIM_2;
      default: short_lim = SHORT_LIM_3;
    endcase
  end
  assign over_short = sense.isense_ma > short_lim;

  // hysteresis in codes; the same code count means fewer volts on small ranges
  assign low_hyst = 13'(LOW_HYST_BASE +
                        LOW_HYST_STEP * {9'd0, config_r[CF_HYST_LSB +: 4]});
  assign surge_hyst = (config_r[CF_VT_LSB +: 2] == 2'd0) ? SURGE_HYST :
                      (config_r[CF_VT_LSB +: 2] == 2'd1) ?
                      13'(SURGE_HYST << 1) : 13'(SURGE_HYST << 2);

  assign uv_low  = digital ? (sense.vin <= low_in_r) : sense.ana_low_in; // RULE_13
  assign uv_ok   = digital ? (vin13 > 13'({1'b0, low_in_r} + low_hyst))
                           : !sense.ana_low_in; // RULE_15
  assign ov_high = digital ? (sense.vin >= high_in_r) : sense.ana_high_in;
  assign ov_clear = digital ? (13'(vin13 + HIGH_HYST) < {1'b0, high_in_r})
                            : !sense.ana_high_in; // RULE_18
  assign surge_high  = sense.vin > surge_r;
  assign surge_clear = 13'(vin13 + surge_hyst) < {1'b0, surge_r}; // RULE_20
  assign ouv_low = digital ? (sense.vout < low_out_r) : sense.ana_low_out;

  // ---------------- deglitch timers ----------------
  assign pd_state = (state_r == ST_FAULT) || (state_r == ST_STBY);
  assign dg_cond = {ouv_low, surge_high, ov_high, uv_low};
  assign dg_act[0] = uv_armed_r && enable_r[FB_LOW_IN] && // RULE_16
                     (state_r inside {ST_STBY, ST_PWRUP, ST_ON, ST_FAULT});
  assign dg_act[1] = enable_r[FB_HIGH_IN] &&
                     (state_r inside {ST_STBY, ST_PWRUP, ST_ON, ST_FAULT});
  assign dg_act[2] = enable_r[FB_SURGE] && // RULE_19
                     (state_r inside {ST_STBY, ST_PWRUP, ST_ON, ST_FAULT});
  assign dg_act[3] = enable_r[FB_LOW_OUT] && (state_r == ST_ON); // RULE_21

  genvar g;
  for (g = 0; g < 4; g++) begin : g_dg
    // counter restarts whenever the condition clears before expiry
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
        dg_cnt[g] <= '0;
      else if (dg_cond[g] && dg_act[g] && !dg_hit[g])
        dg_cnt[g] <= dg_cnt[g] + 1'b1; // RULE_14 RULE_17
      else
        dg_cnt[g] <= '0;
    end
    assign dg_hit[g] = dg_cond[g] && dg_act[g] &&
                       (dg_cnt[g] == CNT_W'(DG_CYC - 1));
  end

  // ---------------- damaged transistor checks ----------------
  assign wd_hit = (state_r == ST_PWRUP) &&
                  (st_cnt_r == CNT_W'(WD_CYC - 1)); // RULE_11
  assign gd_win_hit = pd_state && vgs_hi && !gd_dropped_r &&
                      (st_cnt_r == CNT_W'(GD_WIN_CYC - 1));
  assign f_ds = enable_r[FB_DRAIN_SOURCE] && gate_r.slow_pd && !vgs_hi &&
                over_short && (pd_state || state_r == ST_CHK); // RULE_04
  assign f_gd = enable_r[FB_GATE_DRAIN] &&
                (((state_r == ST_CHK) && vgs_hi && over_short) || // RULE_07
                 gd_win_hit || // RULE_08
                 (pd_state && gd_dropped_r && gate_r.slow_pd &&
                  vgs_hi && over_short)); // RULE_09
  assign f_gs = enable_r[FB_GATE_SOURCE] && wd_hit &&
                !sense.fully_enhanced && !vgs_hi; // RULE_10

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      gd_dropped_r <= 1'b0;
    else if (state_nxt != state_r)
      gd_dropped_r <= 1'b0;
    else if (pd_state && !vgs_hi && gate_r.slow_pd)
      gd_dropped_r <= 1'b1;
  end

  // ---------------- fault collection ----------------
  always_comb begin
    set_vec = '0;
    set_vec[FB_DRAIN_SOURCE] = f_ds;
    set_vec[FB_GATE_DRAIN]   = f_gd;
    set_vec[FB_GATE_SOURCE]  = f_gs;
    set_vec[FB_LOW_IN]       = dg_hit[0];
    set_vec[FB_HIGH_IN]      = dg_hit[1];
    set_vec[FB_SURGE]        = dg_hit[2];
    set_vec[FB_LOW_OUT]      = dg_hit[3];
    set_vec[FB_STORE]        = (state_r == ST_READ) && cfg_mem_err;
    if (set_vec[FB_STORE])                new_cause = CS_MEM;
    else if (f_ds || f_gd || f_gs)        new_cause = CS_DAMAGED; // RULE_03
    else if (dg_hit[2])                   new_cause = CS_SURGE;
    else if (dg_hit[1])                   new_cause = CS_HIGH;
    else if (dg_hit[0])                   new_cause = CS_LOW;
    else if (dg_hit[3])                   new_cause = CS_OUT;
    else if (wd_hit && !sense.fully_enhanced) new_cause = CS_WD;
    else                                  new_cause = CS_NONE;
  end

  // ---------------- controller state ----------------
  always_comb begin
    state_nxt = state_r;
    cause_nxt = cause_r;
    if (new_cause != CS_NONE && state_r != ST_FAULT) begin
      state_nxt = ST_FAULT;
      cause_nxt = new_cause;
    end else begin
      case (state_r)
        ST_POR:   state_nxt = ST_READ;
        ST_READ:  if (cfg_read_done) state_nxt = ST_CHK; // RULE_02
        ST_CHK:   if (st_cnt_r == CNT_W'(CHK_CYC - 1)) state_nxt = ST_STBY;
        ST_STBY:  if (enable_pin && uv_ok && !ov_high && !surge_high)
                    state_nxt = ST_PWRUP; // RULE_15
        ST_PWRUP: if (!enable_pin) state_nxt = ST_STBY;
                  else if (sense.fully_enhanced) state_nxt = ST_ON;
        ST_ON:    if (!enable_pin) state_nxt = ST_STBY;
        ST_FAULT: begin
          // a higher priority fault takes over; the held cause is discarded
          if (new_cause < cause_r) cause_nxt = new_cause;
          else if (cause_r == CS_MEM) state_nxt = ST_MEM; // RULE_01
          else if (!vgs_hi) begin
            case (cause_r)
              CS_DAMAGED: state_nxt = ST_LATCH; // RULE_03
              CS_SURGE:   if (surge_clear) state_nxt = ST_STBY; // RULE_20
              CS_HIGH:    if (ov_clear) state_nxt = ST_STBY; // RULE_18
              CS_LOW:     if (uv_ok) state_nxt = ST_STBY;
              CS_OUT:     state_nxt = config_r[CF_OUV_RETRY] ?
                                      ST_COOL : ST_LATCH; // RULE_21 RULE_22
              default:    state_nxt = ST_COOL;
            endcase
          end
          if (state_nxt != ST_FAULT) cause_nxt = CS_NONE;
        end
        ST_COOL:  if (st_cnt_r == CNT_W'(COOL_CYC - 1))
                    state_nxt = ST_CHK; // RULE_02
        ST_LATCH: if (en_low_seen_r && enable_pin) state_nxt = ST_CHK;
        ST_MEM:   state_nxt = ST_MEM; // RULE_01
        default:  state_nxt = ST_POR;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_POR;
      cause_r <= CS_NONE;
    end else begin
      state_r <= state_nxt;
      cause_r <= cause_nxt;
    end
  end

  // one shared counter times check, watchdog, gate window and cool-down
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      st_cnt_r <= '0;
    else if (state_nxt != state_r)
      st_cnt_r <= '0;
    else if (st_cnt_r != CNT_W'(CMAX))
      st_cnt_r <= st_cnt_r + 1'b1;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      uv_armed_r <= 1'b0;
    else if (state_r == ST_STBY && enable_pin && !uv_low &&
             st_cnt_r >= CNT_W'(ENDG_CYC - 1))
      uv_armed_r <= 1'b1; // RULE_16
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      en_q_r        <= 1'b0;
      en_low_seen_r <= 1'b0;
    end else begin
      en_q_r <= enable_pin;
      if (state_r != ST_LATCH)
        en_low_seen_r <= 1'b0;
      else if (!enable_pin)
        en_low_seen_r <= 1'b1;
    end
  end

  // ---------------- gate and power good ----------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gate_r <= '{on: 1'b0, slow_pd: 1'b1, fast_pd: 1'b0};
      pg_r   <= 1'b0;
    end else begin
      gate_r.on      <= (state_r == ST_PWRUP) || (state_r == ST_ON);
      gate_r.fast_pd <= (state_r == ST_FAULT) &&
                        (cause_r == CS_SURGE); // RULE_19
      gate_r.slow_pd <= !((state_r == ST_PWRUP) || (state_r == ST_ON) ||
                          ((state_r == ST_FAULT) && (cause_r == CS_SURGE)));
      pg_r <= (state_r == ST_ON); // RULE_01
    end
  end

  // ---------------- register bus ----------------
  // one wait cycle per access; waitrequest idles high between accesses
  assign wr_take = avs_write && !wait_r;
  // clear is refused while a fault is still being serviced
  assign clr_req = (state_r != ST_FAULT) &&
                   ((wr_take && avs_address == OFS_STATUS) ||
                    (en_q_r && !enable_pin)); // RULE_23

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      wait_r <= 1'b1;
    else
      wait_r <= !((avs_read || avs_write) && wait_r);
  end

  always_comb begin
    case (avs_address)
      OFS_ENABLE:  rd_mux = {24'h0000_00, enable_r};
      OFS_MASK:    rd_mux = {24'h0000_00, mask_r};
      OFS_STATUS:  rd_mux = {24'h0000_00, status_r};
      OFS_CONFIG:  rd_mux = {22'h00_0000, config_r};
      OFS_LOW_IN:  rd_mux = {20'h0_0000, low_in_r};
      OFS_HIGH_IN: rd_mux = {20'h0_0000, high_in_r};
      OFS_SURGE:   rd_mux = {20'h0_0000, surge_r};
      OFS_LOW_OUT: rd_mux = {20'h0_0000, low_out_r};
      OFS_STATE:   rd_mux = {25'h000_0000, cause_r, state_r};
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      rdata_r <= 32'h0000_0000;
    else if (avs_read && wait_r)
      rdata_r <= rd_mux;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      enable_r  <= RST_ENABLE;
      mask_r    <= RST_MASK;
      config_r  <= RST_CONFIG;
      low_in_r  <= RST_LOW_IN;
      high_in_r <= RST_HIGH_IN;
      surge_r   <= RST_SURGE;
      low_out_r <= RST_LOW_OUT;
    end else if (wr_take) begin
      case (avs_address)
        OFS_ENABLE:  enable_r  <= avs_writedata[NFLT-1:0]; // RULE_06
        OFS_MASK:    mask_r    <= avs_writedata[NFLT-1:0]; // RULE_06
        OFS_CONFIG:  config_r  <= avs_writedata[9:0];
        OFS_LOW_IN:  low_in_r  <= avs_writedata[11:0];
        OFS_HIGH_IN: high_in_r <= avs_writedata[11:0];
        OFS_SURGE:   surge_r   <= avs_writedata[11:0];
        OFS_LOW_OUT: low_out_r <= avs_writedata[11:0];
        default:     ;
      endcase
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= '0;
      fpin_r   <= 1'b0;
    end else begin
      status_r <= (clr_req ? '0 : status_r) | set_vec; // RULE_23 RULE_06
      fpin_r   <= |(status_r & ~mask_r);
    end
  end

  assign avs_readdata      = rdata_r;
  assign avs_waitrequest   = wait_r;
  assign gate_ctl          = gate_r;
  assign power_good_output = pg_r;
  assign fault_output      = fpin_r;

  // ---------------- checks ----------------
  chk_store_latch: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_r == ST_MEM |=> state_r == ST_MEM ##1 !gate_r.on && !pg_r) // RULE_01
    else $error("store fault latch left or gate on");
  chk_damaged_latch: assert property (@(posedge clk_sys) // RULE_03
    disable iff (!reset_n)
    (state_r == ST_FAULT && cause_r == CS_DAMAGED) |=>
      state_r inside {ST_FAULT, ST_LATCH})
    else $error("damaged fault retried");
  chk_ds_status: assert property (@(posedge clk_sys) disable iff (!reset_n)
    f_ds |=> status_r[FB_DRAIN_SOURCE] ##1 fpin_r || mask_r[FB_DRAIN_SOURCE])
    else $error("drain-source fault not reported"); // RULE_04
  chk_status_sticky: assert property (@(posedge clk_sys) // RULE_23
    disable iff (!reset_n)
    !clr_req |=> (status_r & $past(status_r)) == $past(status_r))
    else $error("status bit lost without clear");
  chk_fast_cause: assert property (@(posedge clk_sys) disable iff (!reset_n)
    gate_r.fast_pd |-> $past(state_r) == ST_FAULT &&
                       $past(cause_r) == CS_SURGE) // RULE_19
    else $error("fast pull-down without surge");
  chk_hyst_exit: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_r == ST_PWRUP && $past(state_r) == ST_STBY) |->
      $past(uv_ok)) // RULE_15
    else $error("power-up started below hysteresis");
  chk_gs_watch: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (wd_hit && enable_r[FB_GATE_SOURCE] && !sense.fully_enhanced && !vgs_hi)
      |=> state_r == ST_FAULT && cause_r == CS_DAMAGED) // RULE_10
    else $error("gate-source short missed");
  chk_bus_answer: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ((avs_read || avs_write) && wait_r) |=> !wait_r ##1 wait_r)
    else $error("bus answer not one cycle");
  chk_pg_source: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pg_r |-> $past(state_r) == ST_ON && gate_r.on)
    else $error("power good outside normal state");

  cov_store_fault: cover property (@(posedge clk_sys) disable iff (!reset_n)
    state_r == ST_FAULT ##1 state_r == ST_MEM);
  cov_surge_back: cover property (@(posedge clk_sys) disable iff (!reset_n)
    cause_r == CS_SURGE ##1 state_r == ST_STBY);
  cov_latch_off: cover property (@(posedge clk_sys) disable iff (!reset_n)
    state_r == ST_FAULT ##1 state_r == ST_LATCH);
  cov_normal: cover property (@(posedge clk_sys) disable iff (!reset_n)
    state_r == ST_PWRUP ##1 state_r == ST_ON);
endmodule // hsfd_core

// file: testbench/hsfd_fet_model.sv
`timescale 1ns/1ps
module hsfd_fet_model
  import hsfd_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire hsfd_gate_t gate_ctl,
  input  wire logic       gate_short,
  output logic            vgs_above_1v,
  output logic            fully_enhanced
);
  logic [2:0] lvl_r;
  // gate charge ramps over cycles, never jumps, so off-wait paths are exercised
  // gate_short holds the gate at the source level, as a shorted transistor
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) lvl_r <= 3'h0;
    else if (gate_ctl.on && !gate_short && lvl_r != 3'h7)
      lvl_r <= lvl_r + 3'h1;
    else if ((!gate_ctl.on || gate_short) && lvl_r != 3'h0)
      lvl_r <= lvl_r - 3'h1;
  end
  // no boost pulsing, so the gate-source check may stay enabled
  assign vgs_above_1v   = lvl_r > 3'h1;
  assign fully_enhanced = lvl_r == 3'h7;
endmodule // hsfd_fet_model

// file: testbench/hsfd_core_tb.sv
`timescale 1ns/1ps
module hsfd_core_tb
  import hsfd_pkg::*;
;
  logic        clk_sys = 0, reset_n = 0, avs_read = 0, avs_write = 0;
  logic [5:0]  avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
  logic        avs_waitrequest, power_good_output, fault_output, vgs, full;
  logic        cfg_read_done = 0, cfg_mem_err = 0, enable_pin = 0;
  logic        stuck = 0;
  logic [2:0]  ana = 3'b000;
  logic [11:0] vin = 12'h000, vout = 12'h800;
  logic [15:0] isense = 16'h0000;
  hsfd_gate_t  gate_ctl;
  hsfd_sense_t sense;
  int          n_errors = 0, comparisons = 0, seed = 97;
  assign sense = {vin, vout, isense, vgs, full, ana};
  always #2 clk_sys = ~clk_sys;
  hsfd_core #(.DG_CYC(4), .WD_CYC(40), .GD_WIN_CYC(20), .COOL_CYC(10),
    .CHK_CYC(4), .ENDG_CYC(4)) hsfd_core_i (.clk_sys, .reset_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .sense, .cfg_read_done, .cfg_mem_err, .enable_pin, .gate_ctl,
    .power_good_output, .fault_output);
  hsfd_fet_model hsfd_fet_model_i (.clk_sys, .reset_n, .gate_ctl,
    .gate_short(stuck),
    .vgs_above_1v(vgs), .fully_enhanced(full));
  function automatic int short_lim(input int cs);
    return cs == 0 ? 240 : cs == 1 ? 520 : cs == 2 ? 1100 : 2200;
  endfunction
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        n_errors++;
        wrap_up();
      end
      @(posedge clk_sys);
    end
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge clk_sys);
  endtask
  task automatic poll(input logic [5:0] a, input logic [31:0] m, e);
    int n;
    n = 0;
    bus(0, a, 0);
    while ((q & m) !== e && n < 200) begin
      bus(0, a, 0);
      n++;
    end
    chk(q & m, e);
  endtask
  task automatic power(input logic err);
    reset_n <= 0;
    isense <= 16'h0000;
    cfg_mem_err <= err;
    cfg_read_done <= 1;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1;
    @(posedge clk_sys);
  endtask
  initial begin
    @(posedge clk_sys);
    power(1);
    poll(OFS_STATE, 32'hF, 32'h8);
    chk({gate_ctl.on, power_good_output}, 0);
    chk({fault_output, gate_ctl}, 32'h0000_000A);
    bus(1, OFS_STATUS, 0);
    poll(OFS_STATE, 32'hF, 32'h8);
    chk(fault_output, 0);
    // each range needs a fresh power cycle since the short latches off
    for (int cs = 0; cs < 4; cs++) begin
      power(0);
      // current rises only after the range lands, else the reset range trips
      bus(1, OFS_CONFIG, 32'((cs << 1) | 1));
      isense <= 16'(short_lim(cs) - ($random(seed) & 63));
      repeat (8) @(posedge clk_sys);
      poll(OFS_STATUS, 32'hFF, 32'h0);
      isense <= 16'(short_lim(cs) + 1 + ($random(seed) & 63));
      poll(OFS_STATUS, 32'hFF, 32'h1);
      poll(OFS_STATE, 32'hF, 32'h7);
    end
    power(0);
    isense <= 16'($random(seed) & 127);
    ana <= 3'($random(seed));
    bus(1, OFS_LOW_IN, 32'h0000_0100);
    bus(1, OFS_LOW_OUT, 32'h0000_0080);
    bus(0, 6'h24, 0);
    chk(q, 0);
    poll(OFS_ENABLE, 32'hFF, 32'h7F);
    enable_pin <= 1;
    vin <= 12'h200 + 12'($random(seed) & 32'h3FF);
    vout <= 12'h100 + 12'($random(seed) & 32'h3FF);
    poll(OFS_STATE, 32'hF, 32'h5);
    chk(power_good_output, 1);
    for (int i = 0; i < 2; i++) begin
      bus(1, i ? OFS_HIGH_IN : OFS_SURGE, 32'h0000_0C00);
      vin <= 12'hE00;
      poll(OFS_STATUS, 32'hFF, i ? 32'h10 : 32'h20);
      chk(gate_ctl.on, 0);
      bus(0, OFS_STATE, 0);
      chk(q & 32'hF, 32'h6);
      vin <= 12'hC00 - (i ? 12'h060 : 12'h0E9) - 12'h001;
      poll(OFS_STATE, 32'hF, 32'h5);
      poll(OFS_STATUS, 32'hFF, i ? 32'h10 : 32'h20);
      bus(1, OFS_STATUS, 0);
      poll(OFS_STATUS, 32'hFF, 32'h0);
      bus(1, i ? OFS_HIGH_IN : OFS_SURGE, 32'h0000_0FFF);
    end
    // output one code under its limit in normal state
    vout <= 12'h07F;
    poll(OFS_STATUS, 32'hFF, 32'h40);
    poll(OFS_STATE, 32'hF, 32'h7);
    chk({fault_output, power_good_output, gate_ctl}, 32'h0000_0012);
    // gate held at source level through the watchdog window
    stuck <= 1;
    power(0);
    poll(OFS_STATUS, 32'hFF, 32'h04);
    poll(OFS_STATE, 32'hF, 32'h7);
    wrap_up();
  end
endmodule // hsfd_core_tb
